/* include/fse_pkg.sv */
// shared constants and types for the flash status and error reporting block
package fse_pkg;

    // status byte layout
    localparam int unsigned FSE_STAT_W    = 8;
    localparam int unsigned FSE_BIT_READY = 7;
    localparam int unsigned FSE_BIT_EFAIL = 5;
    localparam int unsigned FSE_BIT_PFAIL = 4;

    // reset values of the flags
    localparam logic FSE_RST_READY = 1'b1;
    localparam logic FSE_RST_FAIL  = 1'b0;

    // command codes carried in the low byte of a command write
    localparam logic [7:0] FSE_CODE_BLK_ERASE  = 8'h20;
    localparam logic [7:0] FSE_CODE_ERASE_ALL  = 8'hA7;
    localparam logic [7:0] FSE_CODE_LOCK_PROG  = 8'h77;
    localparam logic [7:0] FSE_CODE_READ_LOCK  = 8'h71;
    localparam logic [7:0] FSE_CODE_CONFIRM    = 8'hD0;
    localparam logic [7:0] FSE_CODE_CANCEL     = 8'hFF;
    // arbitrary code values for the remaining commands
    localparam logic [7:0] FSE_CODE_PROGRAM    = 8'h4A;
    localparam logic [7:0] FSE_CODE_READ_STAT  = 8'h7A;
    localparam logic [7:0] FSE_CODE_CLEAR_STAT = 8'h5A;

    // operation kinds handed to the rewrite engine
    typedef enum logic [2:0] {
        FSE_OP_NONE,
        FSE_OP_PROGRAM,
        FSE_OP_BLK_ERASE,
        FSE_OP_ERASE_ALL,
        FSE_OP_LOCK_PROG,
        FSE_OP_READ_LOCK
    } fse_op_t;

    // sequencer state
    typedef enum logic {
        FSE_ST_IDLE,
        FSE_ST_BUSY
    } fse_state_t;

endpackage

/* logic/fse_cmd_decode.sv */
// two-cycle command decoder feeding the status core
`timescale 1ns/1ns
module fse_cmd_decode (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            wr_en,
    input  wire logic [7:0]      wr_data,
    input  wire logic            accept,
    output fse_pkg::fse_op_t     pend_op,
    output logic                 go,
    output logic                 seq_err,
    output logic                 to_array,
    output logic                 to_status,
    output logic                 clr_status
);
    import fse_pkg::*;

    fse_op_t next_pend_op;

    // first cycle picks the command, second confirms, cancels or errs
    always_comb begin
        next_pend_op = pend_op;
        go           = 1'b0;
        seq_err      = 1'b0;
        to_array     = 1'b0;
        to_status    = 1'b0;
        clr_status   = 1'b0;
        if (wr_en && accept) begin
            if (pend_op == FSE_OP_NONE) begin
                case (wr_data)
                    FSE_CODE_PROGRAM:    next_pend_op = FSE_OP_PROGRAM;
                    FSE_CODE_BLK_ERASE:  next_pend_op = FSE_OP_BLK_ERASE;
                    FSE_CODE_ERASE_ALL:  next_pend_op = FSE_OP_ERASE_ALL;
                    FSE_CODE_LOCK_PROG:  next_pend_op = FSE_OP_LOCK_PROG;
                    FSE_CODE_READ_LOCK:  next_pend_op = FSE_OP_READ_LOCK;
                    FSE_CODE_READ_STAT:  to_status    = 1'b1;
                    FSE_CODE_CLEAR_STAT: clr_status   = 1'b1;
                    FSE_CODE_CANCEL:     to_array     = 1'b1;
                    default:             next_pend_op = FSE_OP_NONE;
                endcase
            end else begin
                next_pend_op = FSE_OP_NONE;
                if (pend_op == FSE_OP_PROGRAM) begin
                    go = 1'b1;                 // second cycle carries program data
                end else if (wr_data == FSE_CODE_CONFIRM) begin
                    go = 1'b1;
                end else if (wr_data == FSE_CODE_CANCEL) begin
                    to_array = 1'b1;           // first cycle dropped
                end else if (pend_op == FSE_OP_READ_LOCK) begin
                    to_array = 1'b1;
                end else begin
                    seq_err = 1'b1;            // bad second code
                end
            end
        end
    end

    // pending command register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_op <= FSE_OP_NONE;
        end else begin
            pend_op <= next_pend_op;
        end
    end

endmodule // fse_cmd_decode

/* logic/fse_status_core.sv */
// flash rewrite sequencer status flags, error classification and status byte
//
// Contract
// - status read gives ready D7, erase D5, program D4
// - ready flag: 0 busy, 1 ready, resets 1
// - fail flags: 0 normal, 1 error, reset 0
// - clear-status command zeroes both fail flags
// - any fail flag set rejects rewrite commands
// - failed operation sets its matching fail flag
// - bad second code sets both fail flags (after read lock the code goes back to array read, no flags)
// - locked block erase or erase failure: erase error
// - locked program, program or lock fail: program error
// - cancel code drops command, back to array (after the program code it is taken as program data and starts the program)
// - lock check disabled gives no lock errors
// - ready low while any long command executes
// - lock disable unlocks all, stored bits kept
`timescale 1ns/1ns
module fse_status_core (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            wr_en,
    input  wire logic [7:0]      wr_data,
    input  wire logic            rd_en,
    input  wire logic [7:0]      array_rdata,
    output logic      [7:0]      rd_data,
    input  wire logic            lock_check_disable,
    input  wire logic            target_locked,
    output logic                 op_start,
    output fse_pkg::fse_op_t     op_kind,
    input  wire logic            op_done,
    input  wire logic            op_fail,
    output logic                 ctl_seq_ready,
    output logic                 ctl_erase_fail,
    output logic                 ctl_program_fail,
    output logic                 status_mode
);
    import fse_pkg::*;

    fse_state_t state;
    fse_state_t next_state;
    fse_op_t    busy_op;
    fse_op_t    next_busy_op;
    fse_op_t    dec_op;
    logic       efail;
    logic       pfail;
    logic       next_efail;
    logic       next_pfail;
    logic       next_status_mode;
    logic [7:0] next_rd_data;
    logic [7:0] status_byte;
    logic       dec_go;
    logic       dec_seq_err;
    logic       dec_to_array;
    logic       dec_to_status;
    logic       dec_clr;
    logic       blocked;
    logic       lock_hit;
    logic       rewrite_op;
    logic       set_e;
    logic       set_p;

    // command writes are ignored while an operation runs
    fse_cmd_decode u_dec (
        .clk        (clk),
        .rstn       (rstn),
        .wr_en      (wr_en),
        .wr_data    (wr_data),
        .accept     (state == FSE_ST_IDLE),
        .pend_op    (dec_op),
        .go         (dec_go),
        .seq_err    (dec_seq_err),
        .to_array   (dec_to_array),
        .to_status  (dec_to_status),
        .clr_status (dec_clr)
    );

    // flag views and rejection terms
    assign ctl_seq_ready    = (state == FSE_ST_IDLE);
    assign ctl_erase_fail   = efail;
    assign ctl_program_fail = pfail;
    assign op_kind          = dec_op;
    assign blocked          = efail | pfail;
    assign lock_hit         = target_locked & ~lock_check_disable;
    assign rewrite_op       = (dec_op == FSE_OP_PROGRAM) || (dec_op == FSE_OP_BLK_ERASE) ||
                              (dec_op == FSE_OP_ERASE_ALL) || (dec_op == FSE_OP_LOCK_PROG);

    // status byte with reserved bits held at zero
    always_comb begin
        status_byte                = '0;
        status_byte[FSE_BIT_READY] = ctl_seq_ready;
        status_byte[FSE_BIT_EFAIL] = efail;
        status_byte[FSE_BIT_PFAIL] = pfail;
    end

    // sequencer, error classification and read mode
    always_comb begin
        next_state       = state;
        next_busy_op     = busy_op;
        next_status_mode = status_mode;
        op_start         = 1'b0;
        set_e            = 1'b0;
        set_p            = 1'b0;
        case (state)
            FSE_ST_IDLE: begin
                if (dec_go) begin
                    if (rewrite_op) begin
                        next_status_mode = 1'b1;
                    end
                    if (rewrite_op && blocked) begin
                        op_start = 1'b0;
                    end else if (dec_op == FSE_OP_PROGRAM && lock_hit) begin
                        set_p = 1'b1;
                    end else if (dec_op == FSE_OP_BLK_ERASE && lock_hit) begin
                        set_e = 1'b1;
                    end else begin
                        op_start     = 1'b1;
                        next_state   = FSE_ST_BUSY;
                        next_busy_op = dec_op;
                    end
                end
                if (dec_seq_err) begin
                    set_e = 1'b1;
                    set_p = 1'b1;
                end
            end
            FSE_ST_BUSY: begin
                if (op_done) begin
                    next_state   = FSE_ST_IDLE;
                    next_busy_op = FSE_OP_NONE;
                    if (op_fail) begin
                        case (busy_op)
                            FSE_OP_PROGRAM:   set_p = 1'b1;
                            FSE_OP_LOCK_PROG: set_p = 1'b1;
                            FSE_OP_BLK_ERASE: set_e = 1'b1;
                            FSE_OP_ERASE_ALL: set_e = 1'b1;
                            default:          set_e = 1'b0;
                        endcase
                    end
                end
            end
            default: next_state = FSE_ST_IDLE;
        endcase
        if (dec_to_status) begin
            next_status_mode = 1'b1;
        end
        if (dec_to_array) begin
            next_status_mode = 1'b0;
        end
        // a set in the clearing cycle wins
        next_efail = set_e | (efail & ~dec_clr);
        next_pfail = set_p | (pfail & ~dec_clr);
        next_rd_data = rd_data;
        if (rd_en) begin
            next_rd_data = status_mode ? status_byte : array_rdata;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state       <= FSE_ST_IDLE;
            busy_op     <= FSE_OP_NONE;
            efail       <= FSE_RST_FAIL;
            pfail       <= FSE_RST_FAIL;
            status_mode <= 1'b0;
            rd_data     <= '0;
        end else begin
            state       <= next_state;
            busy_op     <= next_busy_op;
            efail       <= next_efail;
            pfail       <= next_pfail;
            status_mode <= next_status_mode;
            rd_data     <= next_rd_data;
        end
    end

    // checks on the flag behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_status_layout: assert property (rd_en && status_mode |=>
        rd_data[FSE_BIT_READY] == $past(ctl_seq_ready) && rd_data[FSE_BIT_EFAIL] == $past(efail)
        && rd_data[FSE_BIT_PFAIL] == $past(pfail) && rd_data[6] == 1'b0 && rd_data[3:0] == 4'h0)
        else $error("status byte layout wrong");
    a_busy_start: assert property (op_start |=> !ctl_seq_ready
        && busy_op == $past(dec_op))
        else $error("ready not low after operation start");
    a_ready_done: assert property (state == FSE_ST_BUSY && op_done
        |=> ctl_seq_ready)
        else $error("ready not back after operation end");
    a_clear_flags: assert property (dec_clr && !set_e && !set_p
        |=> !efail && !pfail)
        else $error("clear status left a flag set");
    a_reject_blocked: assert property (blocked && dec_go && rewrite_op
        |-> !op_start ##1 ctl_seq_ready)
        else $error("rewrite command accepted with error flag set");
    a_seq_error: assert property (dec_seq_err |=> efail && pfail && ctl_seq_ready)
        else $error("command sequence error not flagged");
    a_prog_fail: assert property (state == FSE_ST_BUSY && op_done && op_fail &&
        (busy_op == FSE_OP_PROGRAM || busy_op == FSE_OP_LOCK_PROG) |=> pfail && efail == $past(efail))
        else $error("program failure not flagged");
    a_erase_lock: assert property (dec_go && dec_op == FSE_OP_BLK_ERASE
        && !blocked && target_locked && !lock_check_disable |-> !op_start ##1 (efail && !pfail))
        else $error("locked block erase not flagged");
    a_lock_bypass: assert property (dec_go && lock_check_disable
        && !blocked && rewrite_op |-> op_start)
        else $error("lock check disabled but operation refused");
    a_cancel_array: assert property (dec_to_array
        |=> !status_mode && $stable(efail))
        else $error("cancel did not return to array read");

    c_prog_ok: cover property (op_start && dec_op == FSE_OP_PROGRAM ##[1:50] op_done && !op_fail);
    c_erase_fail: cover property (state == FSE_ST_BUSY && busy_op == FSE_OP_BLK_ERASE && op_fail
        && op_done);
    c_seq_then_clear: cover property (dec_seq_err ##[1:20] dec_clr);
    c_rejected: cover property (blocked && dec_go && rewrite_op);

endmodule // fse_status_core

/* dv/fse_engine_model.sv */
// behavioural rewrite engine answering operation starts of the status core
`timescale 1ns/1ns
module fse_engine_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       op_start,
    input  wire logic [7:0] lat,
    input  wire logic       fail_req,
    output logic            op_done,
    output logic            op_fail
);
    logic [7:0] cnt;
    logic       run;
    // count the operation down, pulse done once, churn the fail line otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run     <= 1'b0;
            cnt     <= 8'h00;
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end else begin
            op_done <= 1'b0;
            op_fail <= ~op_fail; // meaningless outside a done pulse
            if (op_start && !run) begin
                run <= 1'b1;
                cnt <= lat;
            end else if (run && cnt == 8'h00) begin
                run     <= 1'b0;
                op_done <= 1'b1;
                op_fail <= fail_req;
            end else if (run) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule // fse_engine_model

/* dv/tb_fse_status_core.sv */
// testbench for the flash status and error reporting block
`timescale 1ns/1ns
module tb_fse_status_core;
    import fse_pkg::*;
    logic       clk, rstn, wr_en, rd_en, op_start, op_done, op_fail;
    logic       lock_check_disable, target_locked, fail_req;
    logic       ctl_seq_ready, ctl_erase_fail, ctl_program_fail, status_mode;
    logic [7:0] wr_data, array_rdata, rd_data, lat;
    fse_op_t    op_kind;
    int         num_errors, checks, cyc, starts;
    logic [7:0] ca [4] = '{FSE_CODE_PROGRAM, FSE_CODE_BLK_ERASE, FSE_CODE_ERASE_ALL,
                           FSE_CODE_LOCK_PROG};
    logic [7:0] cb [4] = '{8'h55, FSE_CODE_CONFIRM, FSE_CODE_CONFIRM, FSE_CODE_CONFIRM};
    logic [7:0] ef [4] = '{8'h90, 8'hA0, 8'hA0, 8'h90};

    fse_status_core i_dut (.clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .array_rdata(array_rdata), .rd_data(rd_data),
        .lock_check_disable(lock_check_disable), .target_locked(target_locked),
        .op_start(op_start), .op_kind(op_kind), .op_done(op_done), .op_fail(op_fail),
        .ctl_seq_ready(ctl_seq_ready), .ctl_erase_fail(ctl_erase_fail),
        .ctl_program_fail(ctl_program_fail), .status_mode(status_mode));
    fse_engine_model i_eng (.clk(clk), .rstn(rstn), .op_start(op_start), .lat(lat),
        .fail_req(fail_req), .op_done(op_done), .op_fail(op_fail));

    // 125 MHz clock and a cycle ceiling against hangs
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            stop_test;
        end
    end

    // launched operations, counted at the edge that takes them
    always @(posedge clk) begin
        if (op_start)
            starts++;
    end

    // operation kind that a first command code selects
    function automatic fse_op_t kind_of(input logic [7:0] c);
        case (c)
            FSE_CODE_PROGRAM:   kind_of = FSE_OP_PROGRAM;
            FSE_CODE_BLK_ERASE: kind_of = FSE_OP_BLK_ERASE;
            FSE_CODE_ERASE_ALL: kind_of = FSE_OP_ERASE_ALL;
            FSE_CODE_LOCK_PROG: kind_of = FSE_OP_LOCK_PROG;
            FSE_CODE_READ_LOCK: kind_of = FSE_OP_READ_LOCK;
            default:            kind_of = FSE_OP_NONE;
        endcase
    endfunction

    task stop_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // single command write, strobe dropped for one cycle afterwards
    task wr1(input logic [7:0] c);
        wr_en = 1'b1;
        wr_data = c;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~c;
        @(negedge clk);
    endtask
    // two-cycle command written back to back
    task cmd2(input logic [7:0] a, input logic [7:0] b);
        wr_en = 1'b1;
        wr_data = a;
        @(negedge clk);
        wr_data = b;
        chk({5'h00, op_kind}, {5'h00, kind_of(a)});
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~b;
        @(negedge clk);
    endtask
    task rd(input logic [7:0] exp);
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(rd_data, exp);
        @(negedge clk);
    endtask
    task wrdy;
        int n;
        n = 0;
        while (ctl_seq_ready !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, ctl_seq_ready}, 8'h01);
    endtask
    // command, ready level just after it, then the byte read back
    task op(input logic [7:0] a, input logic [7:0] b, input logic f,
            input logic [7:0] l, input logic r, input logic [7:0] s);
        int n0;
        fail_req = f;
        lat = l;
        n0 = starts;
        cmd2(a, b);
        chk(8'(starts - n0), {7'h00, ~r});
        chk({7'h00, ctl_seq_ready}, {7'h00, r});
        wrdy;
        rd(s);
    endtask
    task clr;
        wr1(FSE_CODE_CLEAR_STAT);
        chk({6'h00, ctl_erase_fail, ctl_program_fail}, 8'h00);
    endtask

    // reset, then the command sequences
    initial begin
        {rstn, wr_en, rd_en, lock_check_disable, target_locked, fail_req} = 6'h00;
        wr_data = 8'h00;
        array_rdata = 8'h96;
        lat = 8'h00;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        chk({ctl_seq_ready, ctl_erase_fail, ctl_program_fail,
             status_mode, 4'h0}, 8'h80);
        wr1(FSE_CODE_READ_STAT);
        rd(8'h80);
        op(FSE_CODE_BLK_ERASE, FSE_CODE_CONFIRM, 1'b0, 8'h06, 1'b0, 8'h80);
        op(FSE_CODE_READ_LOCK, FSE_CODE_CONFIRM, 1'b0, 8'h00, 1'b0, 8'h80);
        for (int i = 0; i < 4; i++) begin
            op(ca[i], cb[i], 1'b1, 8'(i * 2), 1'b0, ef[i]);
            for (int j = 0; j < 4; j++)
                op(ca[j], cb[j], 1'b0, 8'h00, 1'b1, ef[i]);
            clr;
        end
        for (int i = 1; i < 4; i++) begin
            wr1(FSE_CODE_READ_STAT);
            op(ca[i], 8'h33, 1'b0, 8'h00, 1'b1, 8'hB0);
            clr;
            op(ca[i], FSE_CODE_CANCEL, 1'b0, 8'h00, 1'b1, 8'h96);
        end
        wr1(FSE_CODE_READ_STAT);
        rd(8'h80);
        target_locked = 1'b1;
        op(ca[1], cb[1], 1'b0, 8'h00, 1'b1, 8'hA0);
        clr;
        op(ca[0], cb[0], 1'b0, 8'h00, 1'b1, 8'h90);
        clr;
        lock_check_disable = 1'b1;
        op(ca[1], cb[1], 1'b0, 8'h02, 1'b0, 8'h80);
        op(ca[0], cb[0], 1'b0, 8'h02, 1'b0, 8'h80);
        lock_check_disable = 1'b0;
        op(ca[1], cb[1], 1'b0, 8'h00, 1'b1, 8'hA0);
        clr;
        stop_test;
    end
endmodule // tb_fse_status_core
